// ### qdp_pkg.sv
// Shared constants and types for the two-wire potentiometer link
package qdp_pkg;
	localparam int POTS = 4;
	localparam int SLOTS = 4;
	localparam int WBITS = 6;
	localparam int TAPS = 64;
	localparam int NV_WRITE_CYCLES = 2500;
	localparam int QTR_CYCLES = 8;
	localparam logic [5:0] SLOT_RESET = 6'h20;
	localparam logic [5:0] WIPER_RESET = 6'h20;
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'ha;
	localparam logic [3:0] OP_RD_SLOT = 4'hb;
	localparam logic [3:0] OP_WR_SLOT = 4'hc;
	localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hd;
	localparam logic [3:0] OP_WIPER_TO_SLOT = 4'he;
	localparam logic [3:0] OP_ALL_SLOT_TO_WIPER = 4'h1;
	localparam logic [3:0] OP_ALL_WIPER_TO_SLOT = 4'h8;
	localparam int CMD_OP_LSB = 4;
	localparam int CMD_SLOT_LSB = 2;
	localparam int CMD_POT_LSB = 0;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FRAME = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int FR_ADDR_LSB = 0;
	localparam int FR_CMD_LSB = 8;
	localparam int FR_DATA_LSB = 16;
	localparam int FR_LEN3_BIT = 24;
	localparam int FR_READ_BIT = 25;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_NACK_BIT = 1;
	localparam int ST_RDATA_LSB = 8;
	localparam logic [31:0] FRAME_RESET = 32'h0000_0000;
	typedef enum logic [3:0] {
		D_IDLE, D_ADDR, D_ACK_ADDR, D_CMD, D_ACK_CMD, D_WDATA, D_ACK_DATA, D_RDATA, D_ACK_RD,
		D_IGNORE
	} qdp_dev_state_t;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} qdp_host_state_t;
endpackage

// ### qdp_if.sv
// Two-wire bus between master and potentiometer slave
interface qdp_if;
	logic scl;
	logic sda;
	logic sda_host_o;
	logic sda_host_oe_n;
	logic sda_dev_o;
	logic sda_dev_oe_n;
	// Pulled-up wired-AND line
	assign sda = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);
	modport device(input scl, input sda, output sda_dev_o, output sda_dev_oe_n);
	modport host(output scl, input sda, output sda_host_o, output sda_host_oe_n);
endinterface

// ### qdp_tap_decode.sv
// One-hot tap switch decoder for one wiper
module qdp_tap_decode
	import qdp_pkg::*;
#(
	parameter int WB = WBITS
)(
	input wire logic [WB-1:0] position,
	output logic [(1<<WB)-1:0] tap_enable
);
	always_comb begin
		tap_enable = '0;
		tap_enable[position] = 1'b1;
	end
endmodule

// ### qdp_device.sv
// Two-wire slave end of the quad digital potentiometer
// Functional notes
// - Serial bits paced only by bus clock
// - Data line pulled low or released only
// - Straps form low four address bits
// - Up to sixteen devices by strap setting
// - Write protect low blocks saved writes
// - Data changes only while clock low
// - Start condition opens every command
// - Ignore bus until a start seen
// - Master ends transaction with stop
// - Transmitter releases line after eight bits
// - Receiver pulls low on ninth pulse; host leaves the line released after a read data byte
// - Ack address, command and data byte
// - Master drives clock; device always slave
// - At most one tap per pot
// - Six-bit position decodes to sixty-four taps
// - Wiper loaded directly or from slot
// - One wiper and four slots per pot
// - Power-up copies first slot to wiper
// - Master sends slave address after start
// - Upper nibble must match type identifier
// - Lower nibble must match all straps
// - Command: opcode, slot select, pot select
// - No address ack while saved write busy
module qdp_device
	import qdp_pkg::*;
#(
	parameter logic [3:0] DEVICE_TYPE_ID = 4'ha, // Arbitrary value
	parameter int NV_CYCLES = NV_WRITE_CYCLES
)(
	input wire logic pclk,
	input wire logic presetn,
	qdp_if.device bus,
	input wire logic [3:0] strap_address_inputs,
	input wire logic write_protect_n,
	output logic [POTS*TAPS-1:0] tap_enable,
	output logic [POTS*WBITS-1:0] wiper_position,
	output logic nv_busy
);
	logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, wp_s1, wp_s2;
	logic [3:0] strap_s1, strap_s2;
	logic scl_rise, scl_fall, start_c, stop_c;
	qdp_dev_state_t st, next_st;
	logic [3:0] cnt, next_cnt;
	logic [7:0] sr, next_sr, cmd, next_cmd;
	logic drive, next_drive, pend, next_pend, pend_all, next_pend_all, recall, next_recall;
	logic [WBITS-1:0] pend_data, next_pend_data, rd_val;
	logic [WBITS-1:0] wiper [POTS];
	logic [WBITS-1:0] next_wiper [POTS];
	logic [WBITS-1:0] slots [POTS][SLOTS];
	logic [WBITS-1:0] next_slots [POTS][SLOTS];
	logic [15:0] busy, next_busy;
	logic [3:0] op;
	logic [1:0] pot, slot;

	// Pin synchronisers and edge history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
			wp_s1 <= 1'b0;
			wp_s2 <= 1'b0;
			strap_s1 <= 4'h0;
			strap_s2 <= 4'h0;
		end else begin
			scl_s1 <= bus.scl;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
			wp_s1 <= write_protect_n;
			wp_s2 <= wp_s1;
			strap_s1 <= strap_address_inputs;
			strap_s2 <= strap_s1;
		end
	end

	assign scl_rise = scl_s2 & ~scl_d;
	assign scl_fall = ~scl_s2 & scl_d;
	assign start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign op = cmd[CMD_OP_LSB +: 4];
	assign pot = cmd[CMD_POT_LSB +: 2];
	assign slot = cmd[CMD_SLOT_LSB +: 2];
	assign rd_val = (op == OP_RD_WIPER) ? wiper[pot] : slots[pot][slot];

	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_sr = sr;
		next_cmd = cmd;
		next_drive = drive;
		next_pend = pend;
		next_pend_all = pend_all;
		next_pend_data = pend_data;
		next_wiper = wiper;
		next_slots = slots;
		next_recall = 1'b0;
		next_busy = busy;
		if (recall) begin
			for (int p = 0; p < POTS; p++) begin
				next_wiper[p] = slots[p][0];
			end
		end
		if (busy != 16'h0000) begin
			next_busy = busy - 16'h0001;
		end
		if (start_c) begin
			next_st = D_ADDR;
			next_cnt = 4'h0;
			next_drive = 1'b0;
			next_pend = 1'b0;
		end else if (stop_c) begin
			next_st = D_IDLE;
			next_drive = 1'b0;
			next_pend = 1'b0;
			if (pend && wp_s2) begin
				for (int p = 0; p < POTS; p++) begin
					if (pend_all || 2'(p) == pot) begin
						next_slots[p][slot] = pend_all ? wiper[p] : pend_data;
					end
				end
				next_busy = 16'(NV_CYCLES);
			end
		end else begin
			case (st)
				D_ADDR, D_CMD, D_WDATA: begin
					if (scl_rise) begin
						next_sr = {sr[6:0], sda_s2};
						next_cnt = cnt + 4'h1;
					end else if (scl_fall && cnt == 4'h8) begin
						next_cnt = 4'h0;
						next_drive = 1'b1;
						if (st == D_ADDR) begin
							if (sr[7:4] == DEVICE_TYPE_ID && sr[3:0] == strap_s2 &&
									busy == 16'h0000) begin
								next_st = D_ACK_ADDR;
							end else begin
								next_drive = 1'b0;
								next_st = D_IGNORE;
							end
						end else if (st == D_CMD) begin
							next_cmd = sr;
							next_st = D_ACK_CMD;
							case (sr[CMD_OP_LSB +: 4])
								OP_SLOT_TO_WIPER: begin
									next_wiper[sr[1:0]] = slots[sr[1:0]][sr[3:2]];
								end
								OP_ALL_SLOT_TO_WIPER: begin
									for (int p = 0; p < POTS; p++) begin
										next_wiper[p] = slots[p][sr[3:2]];
									end
								end
								OP_WIPER_TO_SLOT, OP_ALL_WIPER_TO_SLOT: begin
									next_pend = 1'b1;
									next_pend_all = sr[CMD_OP_LSB +: 4] == OP_ALL_WIPER_TO_SLOT;
									next_pend_data = wiper[sr[1:0]];
								end
								default: begin
								end
							endcase
						end else begin
							next_st = D_ACK_DATA;
							if (op == OP_WR_WIPER) begin
								next_wiper[pot] = sr[WBITS-1:0];
							end else if (op == OP_WR_SLOT) begin
								next_pend = 1'b1;
								next_pend_all = 1'b0;
								next_pend_data = sr[WBITS-1:0];
							end
						end
					end
				end
				D_ACK_ADDR: begin
					if (scl_fall) begin
						next_drive = 1'b0;
						next_st = D_CMD;
					end
				end
				D_ACK_CMD: begin
					if (scl_fall) begin
						next_drive = 1'b0;
						next_st = D_IGNORE;
						next_cnt = 4'h0;
						if (op == OP_RD_WIPER || op == OP_RD_SLOT) begin
							next_sr = {2'b00, rd_val};
							next_drive = 1'b1;
							next_cnt = 4'h1;
							next_st = D_RDATA;
						end else if (op == OP_WR_WIPER || op == OP_WR_SLOT) begin
							next_st = D_WDATA;
						end
					end
				end
				D_RDATA: begin
					if (scl_fall) begin
						if (cnt == 4'h8) begin
							next_drive = 1'b0;
							next_st = D_ACK_RD;
						end else begin
							next_sr = {sr[6:0], 1'b0};
							next_drive = ~sr[6];
							next_cnt = cnt + 4'h1;
						end
					end
				end
				D_ACK_DATA, D_ACK_RD: begin
					if (scl_fall) begin
						next_drive = 1'b0;
						next_st = D_IGNORE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= D_IDLE;
			cnt <= 4'h0;
			sr <= 8'h00;
			cmd <= 8'h00;
			drive <= 1'b0;
			pend <= 1'b0;
			pend_all <= 1'b0;
			pend_data <= 6'h00;
			recall <= 1'b1;
			busy <= 16'h0000;
			for (int p = 0; p < POTS; p++) begin
				wiper[p] <= WIPER_RESET;
				for (int s = 0; s < SLOTS; s++) begin
					slots[p][s] <= SLOT_RESET;
				end
			end
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			sr <= next_sr;
			cmd <= next_cmd;
			drive <= next_drive;
			pend <= next_pend;
			pend_all <= next_pend_all;
			pend_data <= next_pend_data;
			recall <= next_recall;
			busy <= next_busy;
			wiper <= next_wiper;
			slots <= next_slots;
		end
	end

	assign bus.sda_dev_o = 1'b0;
	assign bus.sda_dev_oe_n = ~drive;
	assign nv_busy = busy != 16'h0000;

	for (genvar g = 0; g < POTS; g++) begin : g_pot
		assign wiper_position[g*WBITS +: WBITS] = wiper[g];
		qdp_tap_decode #(.WB(WBITS)) u_dec (
			.position(wiper[g]),
			.tap_enable(tap_enable[g*TAPS +: TAPS])
		);
	end
endmodule

// ### qdp_host.sv
// Two-wire bus master with APB control registers
module qdp_host
	import qdp_pkg::*;
#(
	parameter int QTR = QTR_CYCLES
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	qdp_if.host bus
);
	qdp_host_state_t st, next_st;
	logic [1:0] ph, next_ph, bi, next_bi;
	logic [3:0] k, next_k;
	logic [7:0] shreg, next_shreg, rdata, next_rdata, qcnt;
	logic [31:0] frame, next_frame, next_prdata;
	logic go, next_go, nack, next_nack, scl, next_scl, drive, next_drive;
	logic sda_s1, sda_s2, tick, rd, last, mapped, busy;

	assign tick = qcnt == 8'h00;
	assign busy = st != H_IDLE;
	assign rd = frame[FR_READ_BIT] && bi == 2'd2;
	assign last = bi == (frame[FR_LEN3_BIT] ? 2'd2 : 2'd1);
	assign mapped = paddr == REG_CTRL || paddr == REG_FRAME || paddr == REG_STATUS;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	function automatic logic [7:0] frame_byte(input logic [31:0] f, input logic [1:0] n);
		frame_byte = f[8*n +: 8];
	endfunction

	always_comb begin
		next_st = st;
		next_ph = ph;
		next_bi = bi;
		next_k = k;
		next_shreg = shreg;
		next_rdata = rdata;
		next_frame = frame;
		next_go = go;
		next_nack = nack;
		next_scl = scl;
		next_drive = drive;
		next_prdata = prdata;
		if (psel && !penable) begin
			case (paddr)
				REG_FRAME: next_prdata = frame;
				REG_STATUS: next_prdata = {16'h0000, rdata, 6'h00, nack, busy | go};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
		if (psel && penable && pwrite && !busy && !go) begin
			if (paddr == REG_FRAME) begin
				next_frame = pwdata;
			end else if (paddr == REG_CTRL) begin
				next_go = pwdata[0];
			end
		end
		if (tick) begin
			next_ph = ph + 2'd1;
			case (st)
				H_IDLE: begin
					next_ph = 2'd0;
					next_scl = 1'b1;
					next_drive = 1'b0;
					if (go) begin
						next_go = 1'b0;
						next_nack = 1'b0;
						next_st = H_START;
					end
				end
				H_START: begin
					if (ph == 2'd1) begin
						next_drive = 1'b1;
					end else if (ph == 2'd2) begin
						next_scl = 1'b0;
					end else if (ph == 2'd3) begin
						next_st = H_BIT;
						next_bi = 2'd0;
						next_k = 4'h0;
						next_shreg = frame_byte(frame, 2'd0);
					end
				end
				H_BIT: begin
					if (ph == 2'd0) begin
						next_drive = (k < 4'h8 && !rd) ? ~shreg[7] : 1'b0;
					end else if (ph == 2'd1) begin
						next_scl = 1'b1;
					end else if (ph == 2'd2) begin
						if (k < 4'h8) begin
							next_shreg = {shreg[6:0], sda_s2};
						end else if (!rd && sda_s2) begin
							next_nack = 1'b1;
						end
					end else begin
						next_scl = 1'b0;
						next_k = k + 4'h1;
						if (k == 4'h8) begin
							if (rd) begin
								next_rdata = shreg;
							end
							if (nack || last) begin
								next_st = H_STOP;
							end else begin
								next_bi = bi + 2'd1;
								next_k = 4'h0;
								next_shreg = frame_byte(frame, bi + 2'd1);
							end
						end
					end
				end
				H_STOP: begin
					if (ph == 2'd0) begin
						next_drive = 1'b1;
					end else if (ph == 2'd1) begin
						next_scl = 1'b1;
					end else if (ph == 2'd2) begin
						next_drive = 1'b0;
					end else begin
						next_st = H_IDLE;
					end
				end
				default: next_st = H_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			qcnt <= 8'h00;
			st <= H_IDLE;
			ph <= 2'd0;
			bi <= 2'd0;
			k <= 4'h0;
			shreg <= 8'h00;
			rdata <= 8'h00;
			frame <= FRAME_RESET;
			go <= 1'b0;
			nack <= 1'b0;
			scl <= 1'b1;
			drive <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			sda_s1 <= bus.sda;
			sda_s2 <= sda_s1;
			qcnt <= tick ? 8'(QTR - 1) : qcnt - 8'h01;
			st <= next_st;
			ph <= next_ph;
			bi <= next_bi;
			k <= next_k;
			shreg <= next_shreg;
			rdata <= next_rdata;
			frame <= next_frame;
			go <= next_go;
			nack <= next_nack;
			scl <= next_scl;
			drive <= next_drive;
			prdata <= next_prdata;
		end
	end

	assign bus.scl = scl;
	assign bus.sda_host_o = 1'b0;
	assign bus.sda_host_oe_n = ~drive;
endmodule

// ### qdp_assertions.sv
// Bus-level checks on the two-wire link between host and device
module qdp_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_host_o,
	input wire logic sda_host_oe_n,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic scl_q;
	logic sda_q;
	logic in_frame;
	logic next_in_frame;
	logic start_seen;
	logic stop_seen;
	assign start_seen = scl & scl_q & sda_q & ~sda;
	assign stop_seen = scl & scl_q & ~sda_q & sda;
	always_comb begin
		next_in_frame = in_frame;
		if (start_seen)
			next_in_frame = 1'b1;
		else if (stop_seen)
			next_in_frame = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			in_frame <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			in_frame <= next_in_frame;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_start;
		start_seen ##1 scl [*4];
	endsequence
	sequence s_low_held;
		$fell(sda_dev_oe_n) ##1 !sda_dev_oe_n [*8];
	endsequence
	a_dev_pull_only: assert property (sda_dev_o == 1'b0)
		else $error("device data output not low");
	a_host_pull_only: assert property (sda_host_o == 1'b0)
		else $error("host data output not low");
	a_quiet_idle: assert property (!in_frame |-> sda_dev_oe_n)
		else $error("device drives line outside a frame");
	a_dev_scl_low: assert property ($changed(sda_dev_oe_n) |-> !scl)
		else $error("device changed data while clock high");
	a_ack_stands: assert property ($fell(sda_dev_oe_n) |-> s_low_held)
		else $error("device low bit too short");
	a_dev_release: assert property ($fell(sda_dev_oe_n) |-> ##[1:300] sda_dev_oe_n)
		else $error("device never releases data line");
	a_scl_idle_high: assert property (!in_frame |-> scl)
		else $error("clock not high between frames");
	a_start_hold: assert property (start_seen |-> s_start)
		else $error("clock fell too soon after start");
endmodule

// ### testbench.sv
// Self-checking bench: APB host driving the potentiometer slave
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import qdp_pkg::*;
	localparam logic [3:0] TYPE_ID = 4'ha; // Arbitrary value
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, st;
	logic pready, pslverr, nv_busy, write_protect_n = 1;
	logic [3:0] strap = 4'h3;
	logic [POTS*TAPS-1:0] tap_enable;
	logic [POTS*WBITS-1:0] wiper_position;
	logic [5:0] ew[4];
	logic [5:0] es[4][4];
	int fails = 0, n_tests = 0;
	always #2 pclk = ~pclk;
	qdp_if bus_if();
	qdp_host u_qdp_host(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(bus_if));
	qdp_device #(.DEVICE_TYPE_ID(TYPE_ID), .NV_CYCLES(600)) u_qdp_device(.pclk(pclk),
		.presetn(presetn), .bus(bus_if), .strap_address_inputs(strap),
		.write_protect_n(write_protect_n), .tap_enable(tap_enable),
		.wiper_position(wiper_position), .nv_busy(nv_busy));
	qdp_assertions chk_bus(.pclk(pclk), .presetn(presetn), .scl(bus_if.scl), .sda(bus_if.sda),
		.sda_host_o(bus_if.sda_host_o), .sda_host_oe_n(bus_if.sda_host_oe_n),
		.sda_dev_o(bus_if.sda_dev_o), .sda_dev_oe_n(bus_if.sda_dev_oe_n));
	task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		st = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task xfer(input logic [7:0] ad, cm, d, input logic l3, rd);
		int n;
		apb(1'b1, REG_FRAME, {6'h00, rd, l3, d, cm, ad});
		apb(1'b1, REG_CTRL, 32'h1);
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (st[ST_BUSY_BIT] !== 1'b1 && n < 50);
		chk(st[ST_BUSY_BIT], 1'b1, "frame start");
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (st[ST_BUSY_BIT] !== 1'b0 && n < 3000);
		chk(st[ST_BUSY_BIT], 1'b0, "frame end");
	endtask
	task chk_wipers;
		for (int g = 0; g < POTS; g++) begin
			chk(wiper_position[g*WBITS+:WBITS], ew[g], "wiper");
			chk(tap_enable[g*TAPS+:TAPS], 64'h1 << ew[g], "taps");
		end
	endtask
	task op(input logic [3:0] o, input logic [1:0] s, p, input logic [5:0] d);
		logic l3, rd;
		int k;
		k = 0;
		while (nv_busy !== 1'b0 && k < 2000) begin
			@(posedge pclk);
			k++;
		end
		l3 = o inside {OP_RD_WIPER, OP_WR_WIPER, OP_RD_SLOT, OP_WR_SLOT};
		rd = o inside {OP_RD_WIPER, OP_RD_SLOT};
		xfer({TYPE_ID, strap}, {o, s, p}, {2'b00, d}, l3, rd);
		chk(st[ST_NACK_BIT], 1'b0, "ack");
		case (o)
			OP_WR_WIPER: ew[p] = d;
			OP_WR_SLOT: if (write_protect_n) es[p][s] = d;
			OP_SLOT_TO_WIPER: ew[p] = es[p][s];
			OP_WIPER_TO_SLOT: if (write_protect_n) es[p][s] = ew[p];
			OP_ALL_SLOT_TO_WIPER: foreach (ew[g]) ew[g] = es[g][s];
			OP_ALL_WIPER_TO_SLOT: if (write_protect_n) foreach (ew[g]) es[g][s] = ew[g];
			OP_RD_WIPER: chk(st[15:8], {2'b00, ew[p]}, "wiper read");
			OP_RD_SLOT: chk(st[15:8], {2'b00, es[p][s]}, "slot read");
			default: ;
		endcase
		chk_wipers;
	endtask
	task t_reset;
		foreach (ew[g]) ew[g] = WIPER_RESET;
		foreach (es[g, j]) es[g][j] = SLOT_RESET;
		chk_wipers;
		apb(1'b0, 8'h40, 32'h0);
		chk({err, st}, {1'b1, 32'h0}, "unmapped");
		$display("t_reset done");
	endtask
	task t_wiper;
		logic [5:0] v[4] = '{6'h00, 6'h15, 6'h2a, 6'h3f};
		for (int g = 0; g < POTS; g++) begin
			op(OP_WR_WIPER, 2'b00, g[1:0], v[g]);
			op(OP_RD_WIPER, 2'b00, g[1:0], 6'h00);
		end
		$display("t_wiper done");
	endtask
	task t_strap;
		logic [3:0] v[3] = '{4'h0, 4'h9, 4'hf};
		foreach (v[i]) begin
			strap <= v[i];
			@(posedge pclk);
			op(OP_WR_WIPER, 2'b00, 2'b01, {2'b00, v[i]});
			xfer({TYPE_ID, strap ^ 4'h1}, {OP_WR_WIPER, 4'h1}, 8'h3f, 1'b1, 1'b0);
			chk(st[ST_NACK_BIT], 1'b1, "strap mismatch");
			xfer({TYPE_ID ^ 4'h8, strap}, {OP_WR_WIPER, 4'h1}, 8'h3f, 1'b1, 1'b0);
			chk(st[ST_NACK_BIT], 1'b1, "type mismatch");
			chk_wipers;
		end
		$display("t_strap done");
	endtask
	task t_slots;
		op(OP_WR_SLOT, 2'd3, 2'd1, 6'h15);
		chk(nv_busy, 1'b1, "store running");
		xfer({TYPE_ID, strap}, {OP_WR_WIPER, 4'h1}, 8'h33, 1'b1, 1'b0);
		chk(st[ST_NACK_BIT], 1'b1, "busy nack");
		chk_wipers;
		op(OP_SLOT_TO_WIPER, 2'd3, 2'd1, 6'h00);
		op(OP_RD_SLOT, 2'd3, 2'd1, 6'h00);
		op(OP_WIPER_TO_SLOT, 2'd2, 2'd2, 6'h00);
		op(OP_ALL_WIPER_TO_SLOT, 2'd1, 2'd0, 6'h00);
		op(OP_WR_WIPER, 2'd0, 2'd2, 6'h07);
		op(OP_ALL_SLOT_TO_WIPER, 2'd2, 2'd0, 6'h00);
		op(OP_ALL_SLOT_TO_WIPER, 2'd1, 2'd0, 6'h00);
		$display("t_slots done");
	endtask
	task t_protect;
		write_protect_n <= 1'b0;
		op(OP_WR_SLOT, 2'd0, 2'd3, 6'h11);
		chk(nv_busy, 1'b0, "protected store");
		op(OP_WIPER_TO_SLOT, 2'd0, 2'd3, 6'h00);
		op(OP_RD_SLOT, 2'd0, 2'd3, 6'h00);
		op(OP_SLOT_TO_WIPER, 2'd0, 2'd3, 6'h00);
		write_protect_n <= 1'b1;
		$display("t_protect done");
	endtask
	initial begin
		#250us;
		fails++;
		complete_run;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_wiper;
		t_strap;
		t_slots;
		t_protect;
		complete_run;
	end
endmodule
